// [hdl/sleg_ram_guard.sv]
// module: secure ram segment access gate
`timescale 1ns/1ps
module sleg_ram_guard
(
   input wire logic [15:0] addr_i,
   input wire logic is_mem_i,
   input wire logic boot_en_i,
   input wire logic [15:0] boot_lo_i,
   input wire logic [15:0] boot_hi_i,
   input wire logic in_boot_code_i,
   input wire logic sec_en_i,
   input wire logic [15:0] sec_lo_i,
   input wire logic [15:0] sec_hi_i,
   input wire logic in_sec_code_i,
   output logic blocked_o
);
   logic in_boot_w;
   logic in_sec_w;
   // window compare per segment
   assign in_boot_w = (addr_i >= boot_lo_i) && (addr_i <= boot_hi_i);
   assign in_sec_w = (addr_i >= sec_lo_i) && (addr_i <= sec_hi_i);
   // block unless executing from the owning flash segment
   assign blocked_o = is_mem_i &&
      ((boot_en_i && in_boot_w && !in_boot_code_i) || // RULE_10
       (sec_en_i && in_sec_w && !in_sec_code_i)); // RULE_11
endmodule

// [hdl/sleg_top.sv]
// module: stack limit checking and effective address generation
`timescale 1ns/1ps
// Contract
// RULE_01: working register fifteen is the upward stack pointer to the next free word
// RULE_02: push writes at pointer then increments; pop decrements then reads
// RULE_03: call pushes counter with upper bit forced clear
// RULE_04: exception push places status low byte over counter upper part
// RULE_05: limit register uninitialized after reset; bit zero always reads zero
// RULE_06: every stack pointer effective address compared against limit
// RULE_07: push at pointer equal to limit passes; next push traps
// RULE_08: stack address below fixed floor raises underflow stack error
// RULE_09: software avoids stack indirect read right after a limit write
// RULE_10: boot secure ram reachable only from boot flash code when enabled; code gates operand requests only, stack push/pop not gated
// RULE_11: secure segment ram reachable only from secure flash code when enabled; code gates operand requests only, stack push/pop not gated
// RULE_12: file register address is thirteen-bit direct field, near region only
// RULE_13: file register ops default to register zero; multiply writes register pair
// RULE_14: move instruction may address whole data space
// RULE_15: three-operand first operand register direct; second register, memory or literal
// RULE_16: three-operand modes: direct, indirect, post, pre, five/ten-bit literal
// RULE_17: file direct gives address; register direct uses contents as operand
// RULE_18: plain indirect uses pointer contents unchanged
// RULE_19: post-modified uses pointer then steps it and writes back
// RULE_20: pre-modified steps pointer by signed constant then uses it
// RULE_21: register offset adds pointer and base operand register
// RULE_22: literal offset adds pointer and instruction literal
// RULE_23: stack error is one-cycle trap request with faulting access flagged
// RULE_24: limit register is sixteen-bit software read/write, bit zero ignored
module sleg_top
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire sleg_pkg::sleg_req_t req_i,
   input wire sleg_pkg::sleg_stk_t stk_op_i,
   input wire logic [15:0] sp_val_i,
   input wire logic [15:0] push_data_i,
   input wire logic pc_push_i,
   input wire logic pc_push_exc_i,
   input wire logic [22:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   input wire logic lim_wr_i,
   input wire logic [15:0] lim_wdata_i,
   input wire logic boot_en_i,
   input wire logic [15:0] boot_lo_i,
   input wire logic [15:0] boot_hi_i,
   input wire logic in_boot_code_i,
   input wire logic sec_en_i,
   input wire logic [15:0] sec_lo_i,
   input wire logic [15:0] sec_hi_i,
   input wire logic in_sec_code_i,
   input wire logic [3:0] mul_dst_i,
   input wire logic mul_pair_i,
   input wire logic is_mul_i,
   output sleg_pkg::sleg_res_t res_o,
   output logic [15:0] push_word_lo_o,
   output logic [15:0] push_word_hi_o,
   output logic [15:0] stack_limit_o,
   output logic trap_req_o,
   output logic trap_overflow_o,
   output logic trap_underflow_o,
   output logic [15:0] trap_addr_o,
   output logic [3:0] dst_sel_o,
   output logic dst_pair_o
);
   // ==========================================================
   // stack limit register
   // ==========================================================
   logic [15:0] stack_limit_reg_r;
   logic [15:0] stack_limit_reg_nxt;
   // bit zero forced clear on write
   assign stack_limit_reg_nxt = lim_wdata_i & sleg_pkg::LSB_CLEAR_MASK; // RULE_24

   // no reset: the limit powers up undefined
   always_ff @(posedge clk_i)
   begin
      if (lim_wr_i)
      begin
         stack_limit_reg_r <= stack_limit_reg_nxt; // RULE_05
      end
   end

   // ==========================================================
   // effective address generation
   // ==========================================================
   logic [15:0] lit_w;
   logic [15:0] step_w;
   logic [15:0] ptr_step_w;
   logic [15:0] near_w;
   logic [15:0] file_addr_w;
   logic is_sp_w;
   logic is_mem_w;
   logic wb_en_w;
   logic [15:0] addr_w;
   logic [15:0] operand_w;
   logic blocked_w;

   // literal width select, five or ten bit zero-extended
   assign lit_w = req_i.lit_is_10 ?
      {6'h00, req_i.lit[sleg_pkg::LIT10_W-1:0]} :
      {11'h000, req_i.lit[sleg_pkg::LIT5_W-1:0]}; // RULE_16
   assign step_w = req_i.step;
   // signed step: add or subtract the constant
   assign ptr_step_w = req_i.decrement ? (req_i.ptr_val - step_w) :
      (req_i.ptr_val + step_w); // RULE_19 RULE_20
   // near region direct address, whole space for move
   assign near_w = {3'h0, req_i.file_addr}; // RULE_12
   assign file_addr_w = req_i.full_space ? req_i.lit : near_w; // RULE_14
   assign is_sp_w = (req_i.ptr_sel == 4'(sleg_pkg::SP_INDEX));

   // mode decode into address and operand
   always_comb
   begin
      addr_w = sleg_pkg::ZERO16;
      operand_w = sleg_pkg::ZERO16;
      is_mem_w = 1'b1;
      wb_en_w = 1'b0;
      case (req_i.mode)
         sleg_pkg::SLEG_FILE_DIRECT: addr_w = file_addr_w; // RULE_17
         sleg_pkg::SLEG_REG_DIRECT:
         begin
            operand_w = req_i.ptr_val; // RULE_15 RULE_17
            is_mem_w = 1'b0;
         end
         sleg_pkg::SLEG_REG_IND: addr_w = req_i.ptr_val; // RULE_18
         sleg_pkg::SLEG_IND_POST:
         begin
            addr_w = req_i.ptr_val; // RULE_19
            wb_en_w = 1'b1;
         end
         sleg_pkg::SLEG_IND_PRE:
         begin
            addr_w = ptr_step_w; // RULE_20
            wb_en_w = 1'b1;
         end
         sleg_pkg::SLEG_IND_REG_OFS:
            addr_w = req_i.ptr_val + req_i.base_val; // RULE_21
         sleg_pkg::SLEG_IND_LIT_OFS:
            addr_w = req_i.ptr_val + req_i.lit; // RULE_22
         sleg_pkg::SLEG_LITERAL:
         begin
            operand_w = lit_w; // RULE_15
            is_mem_w = 1'b0;
         end
         default: is_mem_w = 1'b0;
      endcase
   end

   // ==========================================================
   // stack address and checks
   // ==========================================================
   logic push_w;
   logic pop_w;
   logic [15:0] sp_addr_w;
   logic [15:0] sp_new_w;
   logic sp_access_w;
   logic [15:0] chk_addr_w;
   logic over_w;
   logic under_w;
   // push uses pointer then increments; pop decrements then reads
   assign push_w = (stk_op_i == sleg_pkg::SLEG_STK_PUSH) || pc_push_i ||
      pc_push_exc_i;
   assign pop_w = (stk_op_i == sleg_pkg::SLEG_STK_POP);
   assign sp_addr_w = pop_w ? (sp_val_i - sleg_pkg::WORD_STEP) :
      sp_val_i; // RULE_01 RULE_02
   assign sp_new_w = pop_w ? sp_addr_w :
      (sp_val_i + sleg_pkg::WORD_STEP); // RULE_02
   assign sp_access_w = push_w || pop_w ||
      (req_i.valid && is_sp_w && is_mem_w);
   assign chk_addr_w = (push_w || pop_w) ? sp_addr_w : addr_w;
   // compare every stack effective address with the limit
   assign over_w = sp_access_w && (chk_addr_w > stack_limit_reg_r); // RULE_06 RULE_07
   assign under_w = sp_access_w && (chk_addr_w < sleg_pkg::STACK_FLOOR); // RULE_08

   sleg_ram_guard u_guard
   (
      .addr_i(addr_w),
      .is_mem_i(req_i.valid && is_mem_w),
      .boot_en_i(boot_en_i),
      .boot_lo_i(boot_lo_i),
      .boot_hi_i(boot_hi_i),
      .in_boot_code_i(in_boot_code_i),
      .sec_en_i(sec_en_i),
      .sec_lo_i(sec_lo_i),
      .sec_hi_i(sec_hi_i),
      .in_sec_code_i(in_sec_code_i),
      .blocked_o(blocked_w)
   );

   // ==========================================================
   // pushed counter words
   // ==========================================================
   logic [15:0] pc_hi_w;
   logic [15:0] push_lo_w;
   // call zero-extends, exception adds status low byte
   assign pc_hi_w = pc_push_exc_i ?
      {status_low_byte_i, 1'b0, pc_i[22:16]} : // RULE_04
      {sleg_pkg::ZERO8, sleg_pkg::ZERO1, pc_i[22:16]}; // RULE_03
   assign push_lo_w = (pc_push_i || pc_push_exc_i) ?
      {pc_i[15:1], 1'b0} : push_data_i;

   // ==========================================================
   // registered outputs
   // ==========================================================
   sleg_pkg::sleg_res_t res_nxt;
   always_comb
   begin
      res_nxt.valid = req_i.valid || push_w || pop_w;
      res_nxt.is_mem = (req_i.valid && is_mem_w) || push_w || pop_w;
      res_nxt.addr = (push_w || pop_w) ? sp_addr_w : addr_w;
      res_nxt.operand = operand_w;
      res_nxt.wb_en = (req_i.valid && wb_en_w) || push_w || pop_w;
      res_nxt.wb_sel = (push_w || pop_w) ? 4'(sleg_pkg::SP_INDEX) :
         req_i.ptr_sel;
      res_nxt.wb_val = (push_w || pop_w) ? sp_new_w : ptr_step_w;
      res_nxt.blocked = blocked_w || over_w || under_w; // RULE_23
   end

   // destination: default register zero, multiply names its own
   logic [3:0] dst_nxt;
   assign dst_nxt = is_mul_i ? mul_dst_i :
      4'(sleg_pkg::WORK_DEF_INDEX); // RULE_13

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         res_o <= '0;
         push_word_lo_o <= sleg_pkg::ZERO16;
         push_word_hi_o <= sleg_pkg::ZERO16;
         trap_req_o <= 1'b0;
         trap_overflow_o <= 1'b0;
         trap_underflow_o <= 1'b0;
         trap_addr_o <= sleg_pkg::ZERO16;
         dst_sel_o <= 4'h0;
         dst_pair_o <= 1'b0;
         stack_limit_o <= sleg_pkg::ZERO16;
      end
      else
      begin
         res_o <= res_nxt;
         push_word_lo_o <= push_lo_w;
         push_word_hi_o <= pc_hi_w;
         trap_req_o <= over_w || under_w; // RULE_23
         trap_overflow_o <= over_w;
         trap_underflow_o <= under_w;
         trap_addr_o <= chk_addr_w;
         dst_sel_o <= dst_nxt;
         dst_pair_o <= is_mul_i && mul_pair_i;
         stack_limit_o <= stack_limit_reg_r & sleg_pkg::LSB_CLEAR_MASK; // RULE_05
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   property p_push_at_limit; // RULE_07
      @(posedge clk_i) disable iff (!rst_n_i)
      (stk_op_i == sleg_pkg::SLEG_STK_PUSH && !pc_push_i && !pc_push_exc_i
       && sp_val_i == stack_limit_reg_r && sp_val_i >= sleg_pkg::STACK_FLOOR)
      |=> !trap_req_o;
   endproperty
   a_push_at_limit: assert property (p_push_at_limit) else $error("trap at limit"); // RULE_07
   property p_over; // RULE_06
      @(posedge clk_i) disable iff (!rst_n_i)
      (push_w && sp_val_i > stack_limit_reg_r) |=> trap_overflow_o;
   endproperty
   a_over: assert property (p_over) else $error("missing overflow trap"); // RULE_06
   property p_under; // RULE_08
      @(posedge clk_i) disable iff (!rst_n_i)
      (push_w && sp_val_i < sleg_pkg::STACK_FLOOR) |=> trap_underflow_o;
   endproperty
   a_under: assert property (p_under) else $error("missing underflow trap"); // RULE_08
   property p_trap_flag; // RULE_23
      @(posedge clk_i) disable iff (!rst_n_i)
      trap_req_o |-> res_o.blocked;
   endproperty
   a_trap_flag: assert property (p_trap_flag) else $error("trap not flagged"); // RULE_23
   property p_lim_lsb; // RULE_05
      @(posedge clk_i) disable iff (!rst_n_i)
      lim_wr_i |=> ##1 (stack_limit_o[0] == 1'b0);
   endproperty
   a_lim_lsb: assert property (p_lim_lsb) else $error("limit bit zero set"); // RULE_05
   property p_pop; // RULE_02
      @(posedge clk_i) disable iff (!rst_n_i)
      (pop_w && !push_w) |=> (res_o.addr == $past(sp_val_i) - 16'h0002
         && res_o.wb_val == res_o.addr);
   endproperty
   a_pop: assert property (p_pop) else $error("pop address wrong"); // RULE_02
   property p_call_msb; // RULE_03
      @(posedge clk_i) disable iff (!rst_n_i)
      (pc_push_i && !pc_push_exc_i) |=> (push_word_hi_o[15:7] == 9'h000);
   endproperty
   a_call_msb: assert property (p_call_msb) else $error("call upper bits set"); // RULE_03
   property p_exc_srl; // RULE_04
      @(posedge clk_i) disable iff (!rst_n_i)
      pc_push_exc_i |=> (push_word_hi_o[15:8] == $past(status_low_byte_i));
   endproperty
   a_exc_srl: assert property (p_exc_srl) else $error("status byte missing"); // RULE_04
   property p_guard; // RULE_10
      @(posedge clk_i) disable iff (!rst_n_i)
      (blocked_w && req_i.valid) |=> res_o.blocked;
   endproperty
   a_guard: assert property (p_guard) else $error("secure access passed"); // RULE_10
   // post-modified request with no stack operation beside it
   sequence s_post_req;
      req_i.valid && req_i.mode == sleg_pkg::SLEG_IND_POST &&
      !push_w && !pop_w;
   endsequence
   // pointer itself is the address, and a writeback is requested
   property p_post; // RULE_19
      @(posedge clk_i) disable iff (!rst_n_i)
      s_post_req |=> (res_o.addr == $past(req_i.ptr_val) && res_o.wb_en);
   endproperty
   a_post: assert property (p_post) else $error("post addr wrong"); // RULE_19
endmodule

// [inc/sleg_pkg.sv]
// package: constants and types for the stack limit and address generator
package sleg_pkg;
   localparam int DATA_W = 16;
   localparam int NEAR_W = 13;
   localparam int LIT5_W = 5;
   localparam int LIT10_W = 10;
   localparam int SP_INDEX = 15;
   localparam int WORK_DEF_INDEX = 0;
   localparam logic [15:0] STACK_FLOOR = 16'h0800;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] LSB_CLEAR_MASK = 16'hFFFE;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [0:0] ZERO1 = 1'h0;

   // addressing modes, gray coded along the usual order
   typedef enum logic [2:0]
   {
      SLEG_FILE_DIRECT = 3'h0,
      SLEG_REG_DIRECT = 3'h1,
      SLEG_REG_IND = 3'h3,
      SLEG_IND_POST = 3'h2,
      SLEG_IND_PRE = 3'h6,
      SLEG_IND_REG_OFS = 3'h7,
      SLEG_IND_LIT_OFS = 3'h5,
      SLEG_LITERAL = 3'h4
   } sleg_mode_t;

   // stack operation kind
   typedef enum logic [1:0]
   {
      SLEG_STK_NONE = 2'h0,
      SLEG_STK_PUSH = 2'h1,
      SLEG_STK_POP = 2'h3,
      SLEG_STK_OTHER = 2'h2
   } sleg_stk_t;

   // one operand request from the decoder
   typedef struct packed
   {
      logic valid;
      sleg_mode_t mode;
      logic [3:0] ptr_sel;
      logic [3:0] base_sel;
      logic [15:0] ptr_val;
      logic [15:0] base_val;
      logic [15:0] lit;
      logic lit_is_10;
      logic [NEAR_W-1:0] file_addr;
      logic full_space;
      logic decrement;
      logic [15:0] step;
   } sleg_req_t;

   // address result to memory and register file
   typedef struct packed
   {
      logic valid;
      logic is_mem;
      logic [15:0] addr;
      logic [15:0] operand;
      logic wb_en;
      logic [3:0] wb_sel;
      logic [15:0] wb_val;
      logic blocked;
   } sleg_res_t;
endpackage

// [testbench/sleg_sp_model.sv]
// partner model: decoder-side holder of the stack pointer register
`timescale 1ns/1ps
module sleg_sp_model
(
   input wire logic clk_i,
   input wire logic ld_i,
   input wire logic [15:0] ld_val_i,
   input wire sleg_pkg::sleg_res_t res_i,
   output logic [15:0] sp_o = 16'h0800
);
   // ==========================
   // pointer register
   // loads from the bench, else takes stack writebacks of the last result
   always @(posedge clk_i)
   begin
      if (ld_i)
         sp_o <= ld_val_i;
      else if (res_i.wb_en && res_i.wb_sel == 4'hF)
         sp_o <= res_i.wb_val;
   end
endmodule

// [testbench/sleg_top_tb.sv]
// testbench: stack checks, counter pushes, ram guard and address modes
`timescale 1ns/1ps
module sleg_top_tb;
   // ==========================
   // stimulus, results, counters
   logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, pc_push = 1'b0, pc_exc = 1'b0;
   logic lim_wr = 1'b0, b_en = 1'b0, s_en = 1'b0, in_b = 1'b0, in_s = 1'b0;
   logic is_mul = 1'b0, mpair = 1'b0, t_req, t_ovf, t_udf, dpair;
   logic [3:0] mdst = 4'h0, dsel;
   logic [7:0] status_low_byte = 8'h00;
   logic [22:0] pc = 23'h000000;
   logic [15:0] ld_val = 16'h0000, lim_wd = 16'h0000, pdata = 16'h0000;
   logic [15:0] m, sp, p_lo, p_hi, lim_o, t_addr;
   sleg_pkg::sleg_req_t req = '0, r;
   sleg_pkg::sleg_stk_t stk = sleg_pkg::SLEG_STK_NONE;
   sleg_pkg::sleg_res_t res;
   int errors = 0, checks = 0, cycles = 0, seed = 32'hdc27;

   // free-running clock, 4 ns
   always #2 clk = ~clk;

   sleg_top u_sleg_top
   (
      .clk_i(clk), .rst_n_i(rst_n), .req_i(req), .stk_op_i(stk),
      .sp_val_i(sp), .push_data_i(pdata), .pc_push_i(pc_push),
      .pc_push_exc_i(pc_exc), .pc_i(pc), .status_low_byte_i(status_low_byte),
      .lim_wr_i(lim_wr), .lim_wdata_i(lim_wd), .boot_en_i(b_en),
      .boot_lo_i(16'h1000), .boot_hi_i(16'h10FF), .in_boot_code_i(in_b),
      .sec_en_i(s_en), .sec_lo_i(16'h2000), .sec_hi_i(16'h20FF),
      .in_sec_code_i(in_s), .mul_dst_i(mdst), .mul_pair_i(mpair),
      .is_mul_i(is_mul), .res_o(res), .push_word_lo_o(p_lo),
      .push_word_hi_o(p_hi), .stack_limit_o(lim_o), .trap_req_o(t_req),
      .trap_overflow_o(t_ovf), .trap_underflow_o(t_udf),
      .trap_addr_o(t_addr), .dst_sel_o(dsel), .dst_pair_o(dpair)
   );

   sleg_sp_model u_sleg_sp_model
   (
      .clk_i(clk), .ld_i(ld), .ld_val_i(ld_val), .res_i(res), .sp_o(sp)
   );

   // ==========================
   // compares, report, bus steps
   task automatic chk16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk16(nm, {15'h0000, e}, {15'h0000, g});
   endtask

   task automatic done(input string nm);
      $display("test %s finished, errors so far %0d", nm, errors);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one cycle: next falling edge, strobes dropped
   task automatic stp();
      @(negedge clk);
      req.valid = 1'b0;
      stk = sleg_pkg::SLEG_STK_NONE;
      {pc_push, pc_exc, lim_wr, ld} = 4'h0;
   endtask

   task automatic lim_set(input logic [15:0] v);
      lim_wr = 1'b1;
      lim_wd = v;
      stp();
      stp();
      chk16("limit", v & sleg_pkg::LSB_CLEAR_MASK, lim_o);
   endtask

   task automatic sp_load(input logic [15:0] v);
      ld = 1'b1;
      ld_val = v;
      stp();
   endtask

   // push or pop through the stack pointer, then one idle cycle
   task automatic stack_op(input logic pop, input logic [15:0] lim);
      logic [15:0] s;
      logic bad;
      s = sp;
      bad = s > lim || s < sleg_pkg::STACK_FLOOR;
      pdata = 16'($random(seed));
      stk = pop ? sleg_pkg::SLEG_STK_POP : sleg_pkg::SLEG_STK_PUSH;
      stp();
      chk16("stack addr", pop ? s - 16'h0002 : s, res.addr);
      chk16("stack wb", s + (pop ? 16'hFFFE : 16'h0002), res.wb_val);
      chk16("wb sel", 16'h000F, {12'h000, res.wb_sel});
      if (!pop)
      begin
         chk16("push data", pdata, p_lo);
         chk1("trap", bad, t_req);
         chk1("ovf", s > lim, t_ovf);
         chk1("udf", s < sleg_pkg::STACK_FLOOR, t_udf);
         if (bad)
            chk16("trap addr", s, t_addr);
      end
      stp();
      chk1("trap pulse", 1'b0, t_req);
   endtask

   // expected effective address of a request
   function automatic logic [15:0] ea_of(input sleg_pkg::sleg_req_t q);
      logic [15:0] d;
      d = q.decrement ? 16'h0000 - q.step : q.step;
      case (q.mode)
         sleg_pkg::SLEG_FILE_DIRECT:
            ea_of = q.full_space ? q.lit : {3'h0, q.file_addr};
         sleg_pkg::SLEG_IND_PRE: ea_of = q.ptr_val + d;
         sleg_pkg::SLEG_IND_REG_OFS: ea_of = q.ptr_val + q.base_val;
         sleg_pkg::SLEG_IND_LIT_OFS: ea_of = q.ptr_val + q.lit;
         default: ea_of = q.ptr_val;
      endcase
   endfunction

   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         end_of_test();
      end
   end

   // ==========================
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      lim_set(16'h1FFF);
      lim_set(16'h1FFE);
      done("limit");
      // pushes up to and one past the limit, pops, floor
      sp_load(16'h1FFA);
      repeat (4) stack_op(1'b0, 16'h1FFE);
      sp_load(16'h1400);
      repeat (2) stack_op(1'b1, 16'h1FFE);
      sp_load(16'h07FE);
      stack_op(1'b0, 16'h1FFE);
      done("stack");
      // indirect access through the stack pointer, then ram guard
      r = '0;
      r.valid = 1'b1;
      r.mode = sleg_pkg::SLEG_REG_IND;
      r.ptr_sel = 4'hF;
      for (int k = 0; k < 2; k++)
      begin
         r.ptr_val = 16'h1FFE + 16'(k * 2);
         req = r;
         stp();
         chk1("sp ea trap", k == 1, t_req);
      end
      r.ptr_sel = 4'h3;
      {b_en, s_en} = 2'h3;
      for (int g = 0; g < 4; g++)
      begin
         r.ptr_val = g[1] ? 16'h2010 : 16'h1010;
         in_b = g[0];
         in_s = !g[0];
         req = r;
         stp();
         chk1("blocked", g[1] == g[0], res.blocked);
      end
      {b_en, s_en, in_b, in_s} = 4'h0;
      done("guard");
      // counter pushes, call then exception
      for (int e = 0; e < 2; e++)
      begin
         pc = 23'($random(seed));
         status_low_byte = 8'($random(seed));
         stk = sleg_pkg::SLEG_STK_PUSH;
         pc_push = e == 0;
         pc_exc = e == 1;
         stp();
         chk16("pc lo", {pc[15:1], 1'b0}, p_lo);
         chk16("pc hi", {e ? status_low_byte : 8'h00, 1'b0, pc[22:16]}, p_hi);
         stp();
      end
      done("counter");
      // every mode in turn, random fields, wrap corner first
      for (int i = 0; i < 64; i++)
      begin
         r = '0;
         r.valid = 1'b1;
         r.mode = sleg_pkg::sleg_mode_t'(3'(i));
         r.ptr_sel = 4'($random(seed)) & 4'h7;
         {r.ptr_val, r.base_val} = 32'($random(seed));
         {r.lit, r.step} = 32'($random(seed));
         {r.file_addr, r.lit_is_10, r.full_space} = 15'($random(seed));
         {r.decrement, is_mul, mpair, mdst} = 7'($random(seed));
         pdata = 16'($random(seed));
         if (i < 8)
            {r.ptr_val, r.step} = {16'hFFFE, 16'h0002};
         m = r.decrement ? 16'h0000 - r.step : r.step;
         req = r;
         stp();
         if (r.mode == sleg_pkg::SLEG_REG_DIRECT)
            chk16("reg operand", r.ptr_val, res.operand);
         else if (r.mode == sleg_pkg::SLEG_LITERAL)
            chk16("literal", r.lit & (r.lit_is_10 ? 16'h03FF : 16'h001F),
               res.operand);
         else
            chk16("ea", ea_of(r), res.addr);
         if (r.mode == sleg_pkg::SLEG_IND_POST || r.mode == sleg_pkg::SLEG_IND_PRE)
            chk16("ptr wb", r.ptr_val + m, res.wb_val);
         if (r.mode == sleg_pkg::SLEG_REG_IND)
            chk1("no wb", 1'b0, res.wb_en);
         if (r.mode == sleg_pkg::SLEG_FILE_DIRECT)
            chk16("dst", is_mul ? {12'h000, mdst} : 16'h0000, {12'h000, dsel});
         chk1("no trap", 1'b0, t_req);
         chk1("pair", is_mul && mpair, dpair);
         chk1("valid", 1'b1, res.valid);
         chk1("is mem", r.mode != sleg_pkg::SLEG_REG_DIRECT &&
            r.mode != sleg_pkg::SLEG_LITERAL, res.is_mem);
      end
      done("modes");
      end_of_test();
   end
endmodule
